/* sac_map.svh */
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define SAC_DATA_W     12
`define SAC_CNT_W      4
`define SAC_FIFO_DEPTH 4

// ----------------------------------------------------------------
// Field positions of a buffered sample word
// ----------------------------------------------------------------
`define SAC_SMP_D1_LSB 0
`define SAC_SMP_D2_LSB 12

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SAC_RST_THRESH 12'h000
`define SAC_RST_MASK   12'hFFF
`define SAC_RST_CNT    4'h0
`define SAC_RST_FLAG   1'h0

`endif

/* sac_pkg.sv */
`include "sac_map.svh"

package sac_pkg;

  // ----------------------------------------------------------------
  // Mask latch phase
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SAC_MASK_OPEN   = 1'b0,
    SAC_MASK_LOCKED = 1'b1
  } sac_mask_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef logic signed [`SAC_DATA_W-1:0] sac_data_t;

  typedef struct packed {
    sac_data_t data2;
    sac_data_t data1;
  } sac_sample_s;

  typedef struct packed {
    logic                  two_record_sum_mode;
    logic [`SAC_DATA_W-1:0] threshold;
    logic [`SAC_CNT_W-1:0]  arm_sample_count;
  } sac_cfg_s;

endpackage

/* sac_fifo.sv */
`timescale 1ns/1ps
`include "sac_map.svh"

module sac_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = `SAC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready_ff,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid_ff,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // Pointers wrap by overflow, so the depth must be a power of two
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("sac_fifo: unsupported WIDTH or DEPTH");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [AW-1:0]    nxt_wr_ptr;
  logic [AW-1:0]    nxt_rd_ptr;
  logic [AW:0]      nxt_count;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Occupancy
  // ----------------------------------------------------------------
  always_comb begin
    push       = in_valid && in_ready_ff;
    pop        = out_valid_ff && out_ready;
    nxt_wr_ptr = push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
    nxt_rd_ptr = pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
    nxt_count  = count_ff;
    if (push && !pop) begin
      nxt_count = (AW+1)'(count_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_count = (AW+1)'(count_ff - 1'b1);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      count_ff     <= '0;
      in_ready_ff  <= 1'b0;
      out_valid_ff <= 1'b0;
    end else begin
      wr_ptr_ff    <= nxt_wr_ptr;
      rd_ptr_ff    <= nxt_rd_ptr;
      count_ff     <= nxt_count;
      in_ready_ff  <= (nxt_count != (AW+1)'(DEPTH));
      out_valid_ff <= (nxt_count != '0);
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  assign out_data = mem[rd_ptr_ff];

endmodule

/* sac_arm.sv */
// Contract
// - Above threshold: same-sign counter up, other down
// - Below threshold: both counters count down
// - Arm while a counter reaches configured count
// - Sum mode: record holds data1 plus data2
// - Sum mode: sum sign picks counter direction
// - Mask latched once per reset, enable plus read
// - Late mask change sets command window error
// - No deployment current count, no diagnostic result
`timescale 1ns/1ps
`include "sac_map.svh"

module sac_arm #(
  parameter int DATA_W = `SAC_DATA_W,
  parameter int CNT_W  = `SAC_CNT_W,
  parameter int DEPTH  = `SAC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // Sample stream
  input  wire logic                  sample_valid,
  output logic                       sample_ready,
  input  wire sac_pkg::sac_sample_s  sample,
  // Configuration
  input  wire sac_pkg::sac_cfg_s     cfg,
  input  wire logic                  safing_record_enable,
  input  wire logic [DATA_W-1:0]     safing_sample_mask,
  input  wire logic                  mask_write,
  input  wire logic                  safing_control_read_command,
  input  wire logic                  command_window_error_clear,
  // Status
  output logic                       arming,
  output logic                       command_window_error,
  output logic                       mask_locked,
  output logic signed [DATA_W:0]     record_value,
  output logic [CNT_W-1:0]           pos_count,
  output logic [CNT_W-1:0]           neg_count,
  output logic                       deploy_current_valid,
  output logic                       hsd_diag_valid
);
  import sac_pkg::*;

  // Packed carriers are sized by the map header, so the widths must agree
  initial begin
    if (DATA_W != `SAC_DATA_W || CNT_W != `SAC_CNT_W || CNT_W < 1) begin
      $error("sac_arm: DATA_W or CNT_W does not match the sample carrier");
    end
  end

  // ----------------------------------------------------------------
  // Counter helpers
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == '1) ? v : CNT_W'(v + 1'b1);
  endfunction

  function automatic logic [CNT_W-1:0] sat_dec(input logic [CNT_W-1:0] v);
    sat_dec = (v == '0) ? v : CNT_W'(v - 1'b1);
  endfunction

  // ----------------------------------------------------------------
  // Input buffer
  // ----------------------------------------------------------------
  sac_sample_s buf_sample;
  logic        buf_valid;
  logic        take;
  sac_mask_e   mask_state_ff;

  // Draining stalls until the mask is locked and the record enabled
  assign take = buf_valid && safing_record_enable && (mask_state_ff == SAC_MASK_LOCKED);

  sac_fifo #(
    .WIDTH ($bits(sac_sample_s)),
    .DEPTH (DEPTH)
  ) sac_fifo_inst (
    .clock        (clock),
    .resetn       (resetn),
    .in_valid     (sample_valid),
    .in_ready_ff  (sample_ready),
    .in_data      (sample),
    .out_valid_ff (buf_valid),
    .out_ready    (take),
    .out_data     (buf_sample)
  );

  // ----------------------------------------------------------------
  // Mask latch and command window
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mask_shadow_ff;
  logic [DATA_W-1:0] mask_ff;
  logic              cmd_err_ff;
  logic [DATA_W-1:0] nxt_mask_shadow;
  logic [DATA_W-1:0] nxt_mask;
  sac_mask_e         nxt_mask_state;
  logic              nxt_cmd_err;
  logic              late_write;

  always_comb begin
    nxt_mask_shadow = mask_shadow_ff;
    nxt_mask        = mask_ff;
    nxt_mask_state  = mask_state_ff;
    late_write      = 1'b0;
    case (mask_state_ff)
      SAC_MASK_OPEN: begin
        if (mask_write) begin
          nxt_mask_shadow = safing_sample_mask;
        end
        // Only one latch per reset cycle; later changes cannot take effect
        if (safing_record_enable && safing_control_read_command) begin
          nxt_mask       = mask_write ? safing_sample_mask : mask_shadow_ff;
          nxt_mask_state = SAC_MASK_LOCKED;
        end
      end
      SAC_MASK_LOCKED: begin
        late_write = mask_write;
      end
      default: begin
        nxt_mask_state = SAC_MASK_OPEN;
      end
    endcase
    // A new late write in the clearing cycle wins over the clear
    nxt_cmd_err = late_write || (cmd_err_ff && !command_window_error_clear);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mask_shadow_ff <= `SAC_RST_MASK;
      mask_ff        <= `SAC_RST_MASK;
      mask_state_ff  <= SAC_MASK_OPEN;
      cmd_err_ff     <= `SAC_RST_FLAG;
    end else begin
      mask_shadow_ff <= nxt_mask_shadow;
      mask_ff        <= nxt_mask;
      mask_state_ff  <= nxt_mask_state;
      cmd_err_ff     <= nxt_cmd_err;
    end
  end

  // ----------------------------------------------------------------
  // Sample evaluation
  // ----------------------------------------------------------------
  logic signed [DATA_W-1:0] m1;
  logic signed [DATA_W-1:0] m2;
  logic signed [DATA_W:0]   rec;
  logic        [DATA_W:0]   mag;
  logic                     rec_neg;
  logic                     above;

  always_comb begin
    m1 = buf_sample.data1 & mask_ff;
    m2 = buf_sample.data2 & mask_ff;
    // One extra bit keeps the sum of two full-scale samples exact
    if (cfg.two_record_sum_mode) begin
      rec = (DATA_W+1)'(m1) + (DATA_W+1)'(m2);
    end else begin
      rec = (DATA_W+1)'(m1);
    end
    rec_neg = rec[DATA_W];
    mag     = rec_neg ? (DATA_W+1)'(-rec) : rec;
    above   = (mag > {1'b0, cfg.threshold});
  end

  // ----------------------------------------------------------------
  // Event counters and arming
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]       pos_ff;
  logic [CNT_W-1:0]       neg_ff;
  logic                   arm_ff;
  logic signed [DATA_W:0] record_ff;
  logic [CNT_W-1:0]       nxt_pos;
  logic [CNT_W-1:0]       nxt_neg;
  logic                   nxt_arm;
  logic signed [DATA_W:0] nxt_record;

  always_comb begin
    nxt_pos    = pos_ff;
    nxt_neg    = neg_ff;
    nxt_record = record_ff;
    if (take) begin
      nxt_record = rec;
      if (above && !rec_neg) begin
        nxt_pos = sat_inc(pos_ff);
        nxt_neg = sat_dec(neg_ff);
      end else if (above) begin
        nxt_neg = sat_inc(neg_ff);
        nxt_pos = sat_dec(pos_ff);
      end else begin
        nxt_pos = sat_dec(pos_ff);
        nxt_neg = sat_dec(neg_ff);
      end
    end
    // Arming follows the counters level-wise, so removal is as prompt as setting
    nxt_arm = (nxt_pos >= cfg.arm_sample_count) || (nxt_neg >= cfg.arm_sample_count);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pos_ff    <= `SAC_RST_CNT;
      neg_ff    <= `SAC_RST_CNT;
      arm_ff    <= `SAC_RST_FLAG;
      record_ff <= '0;
    end else begin
      pos_ff    <= nxt_pos;
      neg_ff    <= nxt_neg;
      arm_ff    <= nxt_arm;
      record_ff <= nxt_record;
    end
  end

  // ----------------------------------------------------------------
  // Deployment current features
  // ----------------------------------------------------------------
  logic dep_ff;

  // Kept as a register so the pins stay defined; never set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dep_ff <= `SAC_RST_FLAG;
    end else begin
      dep_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign arming               = arm_ff;
  assign command_window_error = cmd_err_ff;
  assign mask_locked          = mask_state_ff;
  assign record_value         = record_ff;
  assign pos_count            = pos_ff;
  assign neg_count            = neg_ff;
  assign deploy_current_valid = dep_ff;
  assign hsd_diag_valid       = dep_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  pos_above_step_a: assert property (
    take && above && !rec_neg |=> pos_ff == sat_inc($past(pos_ff)) && neg_ff == sat_dec($past(neg_ff)))
    else $error("positive event did not step the counters");

  below_both_down_a: assert property (
    take && !above |=> pos_ff == sat_dec($past(pos_ff)) && neg_ff == sat_dec($past(neg_ff)))
    else $error("below-threshold sample did not lower both counters");

  arm_follows_cnt_a: assert property (
    ##1 arm_ff == ((pos_ff >= $past(cfg.arm_sample_count)) || (neg_ff >= $past(cfg.arm_sample_count))))
    else $error("arming does not match the event counters");

  sum_record_store_a: assert property (
    take && cfg.two_record_sum_mode |=> record_ff == (DATA_W+1)'($past(m1)) + (DATA_W+1)'($past(m2)))
    else $error("record does not hold the sum of both samples");

  sum_sign_select_a: assert property (
    take && above && cfg.two_record_sum_mode && rec_neg && !m1[DATA_W-1]
    |=> neg_ff == sat_inc($past(neg_ff)) && pos_ff == sat_dec($past(pos_ff)))
    else $error("sum sign did not choose the counter");

  mask_once_lock_a: assert property (
    mask_state_ff == SAC_MASK_LOCKED |=> mask_state_ff == SAC_MASK_LOCKED && $stable(mask_ff))
    else $error("latched mask changed after lock");

  late_write_err_a: assert property (
    mask_write && mask_state_ff == SAC_MASK_LOCKED |=> cmd_err_ff)
    else $error("late mask change did not flag window error");

  err_sticky_a: assert property (
    cmd_err_ff && !command_window_error_clear |=> cmd_err_ff)
    else $error("window error dropped without a clear");

  err_clear_a: assert property (
    command_window_error_clear && !(mask_write && mask_state_ff == SAC_MASK_LOCKED) |=> !cmd_err_ff)
    else $error("window error not cleared");

  no_deploy_diag_a: assert property (
    !deploy_current_valid && !hsd_diag_valid)
    else $error("deployment current result appeared");

  cnt_saturate_a: assert property (
    take && above && !rec_neg && pos_ff == '1 |=> pos_ff == '1)
    else $error("positive counter wrapped");

  arm_seen_c: cover property (take && above ##1 !arm_ff ##[1:20] arm_ff);

  disarm_seen_c: cover property (arm_ff ##1 take && !above ##1 !arm_ff);

  late_err_c: cover property (mask_state_ff == SAC_MASK_LOCKED && mask_write ##1 cmd_err_ff);

  sum_sign_c: cover property (take && above && cfg.two_record_sum_mode && rec_neg && !m1[DATA_W-1]);

endmodule

/* sac_mcu_model.sv */
`timescale 1ns/1ps

module sac_mcu_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Scenario requests
  input  wire logic        go_lock,
  input  wire logic        go_late,
  input  wire logic [11:0] mask_value,
  // Safing commands
  output logic             mask_write,
  output logic             safing_record_enable,
  output logic             safing_control_read_command,
  output logic [11:0]      safing_sample_mask
);
  logic [1:0] step_ff;

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      step_ff                     <= 2'h0;
      mask_write                  <= 1'b0;
      safing_record_enable        <= 1'b0;
      safing_control_read_command <= 1'b0;
      safing_sample_mask          <= 12'hFFF;
    end else begin
      mask_write                  <= 1'b0;
      safing_control_read_command <= 1'b0;
      case (step_ff)
        2'h0: if (go_lock) begin
          mask_write         <= 1'b1;
          safing_sample_mask <= mask_value;
          step_ff            <= 2'h1;
        end
        2'h1: begin
          safing_record_enable        <= 1'b1;
          safing_control_read_command <= 1'b1;
          step_ff                     <= 2'h2;
        end
        default: if (go_late) begin
          // Late change only when a scenario asks for the fault
          mask_write         <= 1'b1;
          safing_sample_mask <= ~safing_sample_mask;
        end
      endcase
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  import sac_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic               clock;
  logic               resetn;
  logic               sample_valid;
  logic               sample_ready;
  sac_sample_s        sample;
  sac_cfg_s           cfg;
  logic               go_lock;
  logic               go_late;
  logic               mask_write;
  logic               safing_record_enable;
  logic               safing_control_read_command;
  logic [11:0]        safing_sample_mask;
  logic               command_window_error_clear;
  logic               arming;
  logic               command_window_error;
  logic               mask_locked;
  logic signed [12:0] record_value;
  logic [3:0]         pos_count;
  logic [3:0]         neg_count;
  logic               deploy_current_valid;
  logic               hsd_diag_valid;
  int                 num_errors;
  int                 comparisons;
  int                 pc;
  int                 nc;
  int                 er;
  logic [11:0]        lmask;
  logic [31:0]        rnd;

  always #12.5 clock = ~clock;

  sac_arm sac_arm_inst (.clock(clock), .resetn(resetn), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample(sample), .cfg(cfg),
    .safing_record_enable(safing_record_enable), .safing_sample_mask(safing_sample_mask),
    .mask_write(mask_write), .safing_control_read_command(safing_control_read_command),
    .command_window_error_clear(command_window_error_clear), .arming(arming),
    .command_window_error(command_window_error), .mask_locked(mask_locked),
    .record_value(record_value), .pos_count(pos_count), .neg_count(neg_count),
    .deploy_current_valid(deploy_current_valid), .hsd_diag_valid(hsd_diag_valid));

  sac_mcu_model sac_mcu_model_inst (.clock(clock), .resetn(resetn), .go_lock(go_lock),
    .go_late(go_late), .mask_value(lmask), .mask_write(mask_write),
    .safing_record_enable(safing_record_enable),
    .safing_control_read_command(safing_control_read_command),
    .safing_sample_mask(safing_sample_mask));

  // ----------------------------------------------------------------
  // Reference model and checks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int sat(input int v);
    return (v < 0) ? 0 : ((v > 15) ? 15 : v);
  endfunction

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic step(input logic [11:0] d1, input logic [11:0] d2);
    logic signed [11:0] a;
    logic signed [11:0] b;
    a = d1 & lmask;
    b = d2 & lmask;
    er = cfg.two_record_sum_mode ? a + b : a;
    if (((er < 0) ? -er : er) > int'(cfg.threshold)) begin
      pc = sat(pc + ((er >= 0) ? 1 : -1));
      nc = sat(nc + ((er >= 0) ? -1 : 1));
    end else begin
      pc = sat(pc - 1);
      nc = sat(nc - 1);
    end
  endtask

  task automatic cmp_all();
    chk(record_value === 13'(er), "record value");
    chk(pos_count === 4'(pc), "positive count");
    chk(neg_count === 4'(nc), "negative count");
    chk(arming === ((pc >= int'(cfg.arm_sample_count)) || (nc >= int'(cfg.arm_sample_count))), "arming");
  endtask

  // Callers enter and leave 2 ns after a rising edge
  task automatic push(input logic [11:0] d1, input logic [11:0] d2);
    int n;
    sample = {d2, d1};
    sample_valid = 1'b1;
    n = 0;
    // Ready is looked at where it is settled, before the edge that takes the word
    while (sample_ready !== 1'b1 && n < 100) begin
      @(posedge clock);
      #2;
      n++;
    end
    @(posedge clock);
    #2;
    chk(n < 100, "sample refused too long");
  endtask

  task automatic send(input logic [11:0] d1, input logic [11:0] d2);
    push(d1, d2);
    sample_valid = 1'b0;
    repeat (3) @(posedge clock);
    #2;
    step(d1, d2);
    cmp_all();
  endtask

  task automatic pulse_wait(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic test_done();
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    sample_valid = 1'b0;
    sample = '0;
    cfg = '{1'b0, 12'h008, 4'h3};
    go_lock = 1'b0;
    go_late = 1'b0;
    command_window_error_clear = 1'b0;
    num_errors = 0;
    comparisons = 0;
    pc = 0;
    nc = 0;
    er = 0;
    // Clearing bit 2 keeps a sample of -1 below threshold, so the small-sample cases stay small
    lmask = 12'hFFB;
    rnd = 32'h1FAD;
    pulse_wait(12);
    chk(arming === 1'b0 && sample_ready === 1'b0, "reset outputs");
    resetn = 1'b1;
    pulse_wait(1);
    chk(sample_ready === 1'b1, "ready after reset");
    // Fill the buffer while unlocked; samples are signed with sign in top bit
    push(12'h00A, 12'h000);
    push(12'hFFF, 12'h000);
    push(12'h009, 12'h000);
    push(12'h8F0, 12'h000);
    sample_valid = 1'b0;
    pulse_wait(1);
    chk(sample_ready === 1'b0, "buffer full");
    chk(mask_locked === 1'b0, "locked early");
    go_lock = 1'b1;
    pulse_wait(1);
    go_lock = 1'b0;
    pulse_wait(10);
    chk(mask_locked === 1'b1, "mask not locked");
    step(12'h00A, 12'h000);
    step(12'hFFF, 12'h000);
    step(12'h009, 12'h000);
    step(12'h8F0, 12'h000);
    cmp_all();
    // Late change is flagged and leaves the latched mask alone
    go_late = 1'b1;
    pulse_wait(1);
    go_late = 1'b0;
    pulse_wait(3);
    chk(command_window_error === 1'b1, "late write not flagged");
    send(12'h0FF, 12'h000);
    command_window_error_clear = 1'b1;
    pulse_wait(1);
    command_window_error_clear = 1'b0;
    pulse_wait(1);
    chk(command_window_error === 1'b0, "error not cleared");
    // Arm on three, disarm on first small sample, threshold boundary
    repeat (16) send(12'h000, 12'h000);
    for (int i = 0; i < 3; i++) send(12'h00A, 12'h000);
    send(12'hFFF, 12'h000);
    send(12'h008, 12'h000);
    send(12'h009, 12'h000);
    // Sum mode: sign of the sum picks the counter
    cfg.two_record_sum_mode = 1'b1;
    repeat (16) send(12'h000, 12'h000);
    for (int i = 0; i < 3; i++) send(i[0] ? 12'hFFF : 12'h001, 12'h010);
    chk(arming === 1'b1, "sum mode not armed");
    send(12'h001, 12'hFE0);
    cfg.two_record_sum_mode = 1'b0;
    repeat (18) send(12'h00A, 12'h000);
    repeat (18) send(12'hFEC, 12'h000);
    repeat (60) begin
      rnd = lfsr(rnd);
      cfg = '{rnd[31], {3'h0, rnd[30:22]}, rnd[21:18]};
      rnd = lfsr(rnd);
      send(rnd[11:0], rnd[23:12]);
    end
    chk(deploy_current_valid === 1'b0 && hsd_diag_valid === 1'b0, "diag valid");
    test_done();
  end
endmodule
